/* hdl/dl_ctrl_regs.sv */
// Control and status register bank of the single-pin debug link.
`timescale 1ns/10ps
module dl_ctrl_regs
  import dl_pkg::*;
#(
  // Arbitrary neutral revision value.
  parameter logic [3:0] REVISION    = 4'h1,
  parameter int         TMO_CYCLES  = TIMEOUT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       rx_parity_err,
  input  wire logic       rx_frame_err,
  input  wire logic       rx_start_err,
  input  wire logic       bus_err,
  input  wire logic       pin_contention,
  input  wire logic       acc_waiting,
  input  wire logic       ack_req,
  output logic            ack_send,
  output logic            nack_send,
  input  wire logic       access_busy,
  input  wire logic       dir_to_tx,
  input  wire logic       byte_sent,
  input  wire logic       multi_load,
  input  wire logic       bit_tick,
  output logic            tx_hold,
  output logic            parity_check_en,
  output logic            contention_det_en,
  input  wire logic       key_urow_ok,
  input  wire logic       key_prog_ok,
  input  wire logic       key_erase_ok,
  input  wire logic       sys_in_reset,
  input  wire logic       sys_in_sleep,
  input  wire logic       prog_ready,
  input  wire logic       urow_ready,
  input  wire logic       lock_status,
  input  wire logic [2:0] crc_status,
  input  wire logic       phy_wake,
  output logic            sys_reset_out,
  output logic            clk_req,
  output logic [1:0]      link_clock_select,
  output logic            urow_done,
  output logic            urow_session_end,
  output logic            phy_off,
  output logic            link_logic_rst
);

  // ==========================================================
  // Local state
  dl_gap_state_type gap_state;
  dl_gap_state_type next_gap_state;

  logic       bank_rst;
  logic [7:0] link_options_a;
  logic [7:0] link_options_b;
  logic [2:0] error_signature;
  logic       user_row_key_flag;
  logic       mem_program_key_flag;
  logic       erase_key_flag;
  logic [7:0] reset_request_byte;
  logic       clk_req_bit;
  logic       rst_sys_seen;
  logic       reset_out_q;
  logic       err_any;
  logic [2:0] err_code;
  logic       tmo_expired;
  logic       gap_load;
  logic [7:0] gap_count;
  logic       gap_tick;
  logic       gap_busy;
  logic       gap_done;
  logic [7:0] guard_cycles;
  logic [7:0] read_mux;
  logic       wr_opt_a;
  logic       wr_opt_b;
  logic       wr_keys;
  logic       wr_reset_request_byte;
  logic       wr_clkdiv;
  logic       wr_sysctl;
  logic       sys_rst_in_q;

  // Only the link register port reaches the bank; no CPU port.
  assign wr_opt_a  = reg_wr && (reg_addr == OFS_OPT_A);
  assign wr_opt_b  = reg_wr && (reg_addr == OFS_OPT_B);
  assign wr_keys   = reg_wr && (reg_addr == OFS_KEYS);
  assign wr_reset_request_byte = reg_wr && (reg_addr == OFS_RESET_REQUEST_BYTE);
  assign wr_clkdiv = reg_wr && (reg_addr == OFS_CLKDIV);
  assign wr_sysctl = reg_wr && (reg_addr == OFS_SYSCTL);

  // ==========================================================
  // Shutdown and bank reset
  // The system reset request is not part of bank_rst, so the
  // link keeps talking while the rest of the chip is held.
  assign bank_rst = sys_rst || link_logic_rst;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_logic_rst <= 1'b0;
    end else begin
      link_logic_rst <= wr_opt_b && reg_wdata[SHUT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy_off <= 1'b0;
    end else if (wr_opt_b && reg_wdata[SHUT_BIT]) begin
      phy_off <= 1'b1;
    end else if (phy_wake) begin
      phy_off <= 1'b0;
    end
  end

  // ==========================================================
  // Option registers
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      link_options_a <= OPT_RST;
    end else if (wr_opt_a) begin
      link_options_a <= reg_wdata & OPT_A_MASK;
    end
  end

  // The shutdown bit is never stored: it resets the bank anyway.
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      link_options_b <= OPT_RST;
    end else if (wr_opt_b) begin
      link_options_b <= reg_wdata & OPT_B_MASK &
                        ~(8'h01 << SHUT_BIT);
    end
  end

  assign parity_check_en   = !link_options_a[PAR_BIT];
  assign contention_det_en = !link_options_b[CCD_BIT];

  // ==========================================================
  // Error signature
  dl_timeout #(
    .CYCLES (TMO_CYCLES)
  ) u_timeout (
    .clk         (clk),
    .rst         (bank_rst),
    .waiting     (acc_waiting),
    .disable_det (link_options_a[TMO_BIT]),
    .expired     (tmo_expired)
  );

  // Several faults in one cycle keep the most severe code.
  always_comb begin
    err_any  = 1'b1;
    err_code = ERR_NONE;
    if (pin_contention && contention_det_en) begin
      err_code = ERR_CONTEND;
    end else if (bus_err) begin
      err_code = ERR_BUS;
    end else if (rx_start_err) begin
      err_code = ERR_START;
    end else if (tmo_expired) begin
      err_code = ERR_TIMEOUT;
    end else if (rx_frame_err) begin
      err_code = ERR_FRAME;
    end else if (rx_parity_err && parity_check_en) begin
      err_code = ERR_PARITY;
    end else begin
      err_any = 1'b0;
    end
  end

  // A new error beats the clear of a read in the same cycle.
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      error_signature <= ERR_NONE;
    end else if (err_any) begin
      error_signature <= err_code;
    end else if (reg_rd && (reg_addr == OFS_ERRSIG)) begin
      error_signature <= ERR_NONE;
    end
  end

  // ==========================================================
  // Acknowledge control
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      ack_send <= 1'b0;
    end else begin
      ack_send <= ack_req && !link_options_a[ACK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      sys_rst_in_q <= 1'b0;
      nack_send    <= 1'b0;
    end else begin
      sys_rst_in_q <= sys_in_reset;
      nack_send    <= sys_in_reset && !sys_rst_in_q &&
                      access_busy &&
                      !link_options_b[NACK_BIT];
    end
  end

  // ==========================================================
  // Transmit gaps
  // Reserved guard code 7 falls back to the shortest gap.
  always_comb begin
    if (link_options_a[2:0] == GUARD_RSVD) begin
      guard_cycles = GUARD_MIN_CYC;
    end else begin
      guard_cycles = GUARD_MAX_CYC >> link_options_a[2:0];
    end
  end

  always_comb begin
    next_gap_state = gap_state;
    gap_load       = 1'b0;
    gap_count      = guard_cycles;
    case (gap_state)
      GAP_IDLE: begin
        if (dir_to_tx) begin
          next_gap_state = GAP_GUARD;
          gap_load       = 1'b1;
        end else if (byte_sent && multi_load &&
                     link_options_a[IBD_BIT]) begin
          next_gap_state = GAP_BYTE;
          gap_load       = 1'b1;
          gap_count      = IDLE_BITS;
        end
      end
      GAP_GUARD, GAP_BYTE: begin
        if (gap_done) begin
          next_gap_state = GAP_IDLE;
        end
      end
      default: begin
        next_gap_state = GAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      gap_state <= GAP_IDLE;
    end else begin
      gap_state <= next_gap_state;
    end
  end

  // Guard time counts link cycles, the byte gap counts bit periods.
  assign gap_tick = (gap_state == GAP_GUARD) ? 1'b1 : bit_tick;
  assign tx_hold  = (gap_state != GAP_IDLE) || gap_busy;

  dl_gap_timer #(
    .W (8)
  ) u_gap (
    .clk   (clk),
    .rst   (bank_rst),
    .load  (gap_load),
    .count (gap_count),
    .tick  (gap_tick),
    .busy  (gap_busy),
    .done  (gap_done)
  );

  // ==========================================================
  // Key flags
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      user_row_key_flag <= 1'b0;
    end else if (key_urow_ok) begin
      user_row_key_flag <= 1'b1;
    end else if (wr_keys && reg_wdata[UROW_BIT]) begin
      user_row_key_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      urow_session_end <= 1'b0;
    end else begin
      urow_session_end <= wr_keys && reg_wdata[UROW_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      mem_program_key_flag <= 1'b0;
    end else if (key_prog_ok) begin
      mem_program_key_flag <= 1'b1;
    end else if (prog_ready) begin
      mem_program_key_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      erase_key_flag <= 1'b0;
    end else if (key_erase_ok) begin
      erase_key_flag <= 1'b1;
    end else if (sys_reset_out && !reset_out_q) begin
      erase_key_flag <= 1'b0;
    end
  end

  // ==========================================================
  // System reset request and clocking
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      reset_request_byte <= RESET_REQUEST_BYTE_RST;
    end else if (wr_reset_request_byte) begin
      reset_request_byte <= reg_wdata;
    end
  end

  // Reserved request values release the reset like RUN does.
  assign sys_reset_out = (reset_request_byte == RESET_REQUEST_BYTE_SIG);

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      reset_out_q <= 1'b0;
    end else begin
      reset_out_q <= sys_reset_out;
    end
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      rst_sys_seen <= 1'b0;
    end else if (sys_in_reset || sys_reset_out) begin
      rst_sys_seen <= 1'b1;
    end else if (reg_rd && (reg_addr == OFS_SYSSTAT)) begin
      rst_sys_seen <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      link_clock_select <= CLKSEL_RST;
    end else if (wr_clkdiv) begin
      link_clock_select <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      clk_req_bit <= CLKREQ_RST;
    end else if (wr_sysctl) begin
      clk_req_bit <= reg_wdata[CLKREQ_BIT];
    end
  end

  assign clk_req = clk_req_bit && !phy_off;

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      urow_done <= 1'b0;
    end else begin
      urow_done <= wr_sysctl && reg_wdata[UDONE_BIT] &&
                   user_row_key_flag;
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    read_mux = 8'h00;
    case (reg_addr)
      OFS_REVISION: read_mux = {REVISION, 4'h0};
      OFS_ERRSIG:   read_mux = {5'h00, error_signature};
      OFS_OPT_A:    read_mux = link_options_a;
      OFS_OPT_B:    read_mux = link_options_b;
      OFS_KEYS:     read_mux = {2'h0, user_row_key_flag,
                                mem_program_key_flag,
                                erase_key_flag, 3'h0};
      OFS_RESET_REQUEST_BYTE:   read_mux = reset_request_byte;
      OFS_CLKDIV:   read_mux = {6'h00, link_clock_select};
      OFS_SYSCTL:   read_mux = {7'h00, clk_req_bit};
      OFS_SYSSTAT:  read_mux = {2'h0, rst_sys_seen, sys_in_sleep,
                                prog_ready, urow_ready, 1'b0,
                                lock_status};
      OFS_CRC:      read_mux = {5'h00, crc_status};
      default:      read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end
  end

endmodule

/* inc/dl_pkg.sv */
// Constants shared by the debug link control and status bank.
// Overview of operation
// - Bank reachable only through link register port
// - Upper nibble of first register shows revision
// - Error code loads on error, clears on read
// - Error codes: parity, frame, timeout, start, bus, contention
// - Inter-byte delay inserts two idle bits
// - Parity ignore bit masks parity errors entirely
// - Access layer silent 65536 cycles flags timeout
// - Ack signature off suppresses positive acknowledges only
// - Guard code selects 128 down to 2 cycles
// - Neg ack off suppresses reset-during-access nack
// - Contention detection active while its bit zero
// - Shutdown bit stops phy, clock request, resets bank
// - User row key flag sets; write ends session
// - Program key flag clears when programming ready
// - Erase key flag clears when reset takes effect
// - Reset signature write asserts system reset
// - 0x59 asserts reset, 0x00 releases, bank excluded
// - Clock select: 16, 8, 4 MHz, default 4
package dl_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] OFS_REVISION = 4'h0;
  localparam logic [3:0] OFS_ERRSIG   = 4'h1;
  localparam logic [3:0] OFS_OPT_A    = 4'h2;
  localparam logic [3:0] OFS_OPT_B    = 4'h3;
  localparam logic [3:0] OFS_KEYS     = 4'h7;
  localparam logic [3:0] OFS_RESET_REQUEST_BYTE   = 4'h8;
  localparam logic [3:0] OFS_CLKDIV   = 4'h9;
  localparam logic [3:0] OFS_SYSCTL   = 4'hA;
  localparam logic [3:0] OFS_SYSSTAT  = 4'hB;
  localparam logic [3:0] OFS_CRC      = 4'hC;

  // ==========================================================
  // Field positions
  localparam int IBD_BIT    = 7;
  localparam int PAR_BIT    = 5;
  localparam int TMO_BIT    = 4;
  localparam int ACK_BIT    = 3;
  localparam int NACK_BIT   = 4;
  localparam int CCD_BIT    = 3;
  localparam int SHUT_BIT   = 2;
  localparam int UROW_BIT   = 5;
  localparam int NVM_BIT    = 4;
  localparam int ERASE_BIT  = 3;
  localparam int CLKREQ_BIT = 0;
  localparam int UDONE_BIT  = 1;
  localparam logic [7:0] OPT_A_MASK = 8'hBF;
  localparam logic [7:0] OPT_B_MASK = 8'h1C;

  // ==========================================================
  // Reset values and codes
  localparam logic [7:0] OPT_RST     = 8'h00;
  localparam logic [7:0] RESET_REQUEST_BYTE_RST  = 8'h00;
  localparam logic [7:0] RESET_REQUEST_BYTE_SIG  = 8'h59;
  localparam logic [7:0] RESET_REQUEST_BYTE_RUN  = 8'h00;
  localparam logic [1:0] CLKSEL_RST  = 2'h3;
  localparam logic [1:0] CLKSEL_16M  = 2'h1;
  localparam logic [1:0] CLKSEL_8M   = 2'h2;
  localparam logic [1:0] CLKSEL_4M   = 2'h3;
  localparam logic       CLKREQ_RST  = 1'b1;

  localparam logic [2:0] ERR_NONE    = 3'h0;
  localparam logic [2:0] ERR_PARITY  = 3'h1;
  localparam logic [2:0] ERR_FRAME   = 3'h2;
  localparam logic [2:0] ERR_TIMEOUT = 3'h3;
  localparam logic [2:0] ERR_START   = 3'h4;
  localparam logic [2:0] ERR_BUS     = 3'h6;
  localparam logic [2:0] ERR_CONTEND = 3'h7;

  // ==========================================================
  // Cycle counts
  localparam int         TIMEOUT_CYCLES = 65536;
  localparam logic [7:0] GUARD_MAX_CYC  = 8'h80;
  localparam logic [7:0] GUARD_MIN_CYC  = 8'h02;
  localparam logic [2:0] GUARD_RSVD     = 3'h7;
  localparam logic [7:0] IDLE_BITS      = 8'h02;

  typedef enum logic [1:0] {
    GAP_IDLE  = 2'b00,
    GAP_GUARD = 2'b01,
    GAP_BYTE  = 2'b11
  } dl_gap_state_type;

endpackage

/* hdl/dl_gap_timer.sv */
// Down counter for guard time and inter-byte idle gaps.
`timescale 1ns/10ps
module dl_gap_timer
  import dl_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  input  wire logic         tick,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] remain;

  assign busy = (remain != '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (busy && tick) begin
      remain <= remain - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= !load && tick && (remain == {{(W-1){1'b0}}, 1'b1});
    end
  end

endmodule

/* hdl/dl_timeout.sv */
// Watchdog on the access layer response while a request waits.
`timescale 1ns/10ps
module dl_timeout
  import dl_pkg::*;
#(
  parameter int CYCLES = TIMEOUT_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic waiting,
  input  wire logic disable_det,
  output logic      expired
);

  localparam int CW = $clog2(CYCLES) + 1;
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

  logic [CW-1:0] elapsed;

  // Counting stops once expired so one wait gives one flag.
  always_ff @(posedge clk) begin
    if (rst || !waiting || disable_det) begin
      elapsed <= '0;
    end else if (elapsed != LIMIT) begin
      elapsed <= elapsed + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      expired <= 1'b0;
    end else begin
      expired <= waiting && !disable_det &&
                 (elapsed == LIMIT - {{(CW-1){1'b0}}, 1'b1});
    end
  end

endmodule

/* sim/dl_link_host.sv */
// Behavioural debugger model that drives the link register port.
`timescale 1ns/10ps
module dl_link_host (
  input  wire logic clk,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_wr,
  output logic       reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;

  // ==========================================================
  // Register accesses
  // Released address and data are inverted to expose stale use.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

/* sim/dl_ctrl_regs_assertions.sv */
// Port-level checks for the debug link control and status bank.
`timescale 1ns/10ps
module dl_ctrl_regs_checker
  import dl_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       ack_req,
  input wire logic       ack_send,
  input wire logic       nack_send,
  input wire logic       access_busy,
  input wire logic       sys_in_reset,
  input wire logic       dir_to_tx,
  input wire logic       byte_sent,
  input wire logic       multi_load,
  input wire logic       tx_hold,
  input wire logic       parity_check_en,
  input wire logic       contention_det_en,
  input wire logic       sys_reset_out,
  input wire logic       clk_req,
  input wire logic [1:0] link_clock_select,
  input wire logic       phy_off,
  input wire logic       link_logic_rst
);
  logic [7:0] opt_a;
  logic [7:0] opt_b;

  // ==========================================================
  // Shadow options
  // Options are rebuilt from port writes; the bank is opaque here.
  always_ff @(posedge clk) begin
    if (sys_rst || link_logic_rst) begin
      opt_a <= 8'h00;
      opt_b <= 8'h00;
    end else if (reg_wr && reg_addr == OFS_OPT_A) begin
      opt_a <= reg_wdata & OPT_A_MASK;
    end else if (reg_wr && reg_addr == OFS_OPT_B) begin
      opt_b <= reg_wdata & OPT_B_MASK;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Properties
  chk_ack_sent:
    assert property (ack_req && !opt_a[ACK_BIT] |=> ack_send)
    else $error("acknowledge missing");
  chk_ack_quiet:
    assert property (ack_send |-> $past(ack_req) && !$past(opt_a[ACK_BIT]))
    else $error("acknowledge without cause");
  chk_parity_mask:
    assert property (parity_check_en == !opt_a[PAR_BIT])
    else $error("parity check enable wrong");
  chk_contend_mask:
    assert property (contention_det_en == !opt_b[CCD_BIT])
    else $error("contention detect enable wrong");
  chk_nack_sent:
    assert property ($rose(sys_in_reset) && access_busy && !opt_b[NACK_BIT]
                     |-> ##[1:2] nack_send)
    else $error("negative acknowledge missing");
  chk_reset_req:
    assert property (reg_wr && reg_addr == OFS_RESET_REQUEST_BYTE
                     |=> sys_reset_out == ($past(reg_wdata) == RESET_REQUEST_BYTE_SIG))
    else $error("system reset request wrong");
  chk_link_shutdown:
    assert property (reg_wr && reg_addr == OFS_OPT_B && reg_wdata[SHUT_BIT]
                     |=> link_logic_rst ##[0:1] (phy_off && !clk_req))
    else $error("shutdown sequence wrong");
  chk_clock_sel:
    assert property (reg_wr && reg_addr == OFS_CLKDIV
                     |=> link_clock_select == 2'($past(reg_wdata)))
    else $error("clock select not taken");
  chk_guard_start:
    assert property (dir_to_tx |=> tx_hold [*2])
    else $error("guard time too short");
  chk_gap_start:
    assert property (byte_sent && multi_load && opt_a[IBD_BIT] |=> tx_hold)
    else $error("inter-byte gap missing");
endmodule

bind dl_ctrl_regs dl_ctrl_regs_checker u_chk (
  .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .ack_req, .ack_send,
  .nack_send, .access_busy, .sys_in_reset, .dir_to_tx, .byte_sent,
  .multi_load, .tx_hold, .parity_check_en, .contention_det_en,
  .sys_reset_out, .clk_req, .link_clock_select, .phy_off, .link_logic_rst
);

/* sim/debug_link_ctrl_status_regs_test.sv */
// Self-checking bench for the debug link control and status bank.
`timescale 1ns/10ps
module debug_link_ctrl_status_regs_test;
  import dl_pkg::*;
  localparam int TMO = 16;
  localparam logic [3:0] RA [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8,
                                    4'h9, 4'hA};
  localparam logic [7:0] RV [8] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
                                    8'h00, 8'h03, 8'h01};
  localparam logic [4:0] EV [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10,
                                    5'h11, 5'h01};
  localparam logic [2:0] EC [7] = '{ERR_PARITY, ERR_FRAME, ERR_START,
                          ERR_BUS, ERR_CONTEND, ERR_CONTEND, ERR_NONE};
  logic       clk, sys_rst, reg_wr, reg_rd, rd_seen, seen;
  logic       acc_waiting, ack_req, ack_send, nack_send, access_busy;
  logic       dir_to_tx, byte_sent, multi_load, bit_tick, tx_hold;
  logic       parity_check_en, contention_det_en, key_u, key_p, key_e;
  logic       sys_in_reset, sys_in_sleep, prog_ready, urow_ready;
  logic       lock_status, phy_wake, sys_reset_out, clk_req, urow_done;
  logic       urow_session_end, phy_off, link_logic_rst;
  logic [1:0] link_clock_select;
  logic [2:0] crc_status;
  logic [3:0] reg_addr;
  logic [4:0] ev;
  logic [7:0] reg_wdata, reg_rdata;
  logic [7:0] exp_q[$];
  int         errors, n_compared, g, n, r;
  int         seed = 26550;

  dl_ctrl_regs #(.TMO_CYCLES(TMO)) i_dut (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_parity_err(ev[0]), .rx_frame_err(ev[1]), .rx_start_err(ev[2]),
    .bus_err(ev[3]), .pin_contention(ev[4]), .acc_waiting, .ack_req,
    .ack_send, .nack_send, .access_busy, .dir_to_tx, .byte_sent,
    .multi_load, .bit_tick, .tx_hold, .parity_check_en,
    .contention_det_en, .key_urow_ok(key_u), .key_prog_ok(key_p),
    .key_erase_ok(key_e), .sys_in_reset, .sys_in_sleep, .prog_ready,
    .urow_ready, .lock_status, .crc_status, .phy_wake, .sys_reset_out,
    .clk_req, .link_clock_select, .urow_done, .urow_session_end,
    .phy_off, .link_logic_rst
  );
  dl_link_host i_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  // ==========================================================
  // Helpers
  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
    n_compared++;
    if (seen_v !== exp_v) begin
      errors++;
      $display("[ERR] %0t: got %h, expected %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Read data is registered, so it is judged one cycle after the strobe.
  always @(posedge clk) rd_seen <= reg_rd && !sys_rst;
  always @(negedge clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      check(reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[ERR] %0t: watchdog expired", $time);
    summarize();
  end

  // ==========================================================
  // Scenarios
  initial begin
    {ev, acc_waiting, ack_req, access_busy, dir_to_tx, byte_sent} = '0;
    {multi_load, bit_tick, key_u, key_p, key_e, sys_in_reset} = '0;
    {prog_ready, phy_wake} = '0;
    r = $random(seed);
    {sys_in_sleep, urow_ready, lock_status, crc_status} = r[5:0];
    sys_rst = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    i_host.wr(OFS_REVISION, 8'hFF);
    for (int i = 0; i < 8; i++) rd(RA[i], RV[i]);
    rd(OFS_SYSSTAT, {3'h0, sys_in_sleep, 1'b0, urow_ready, 1'b0,
                     lock_status});
    rd(OFS_CRC, {5'h00, crc_status});
    for (int a = 4; a < 16; a += (a == 6) ? 7 : 1) begin
      r = $random(seed);
      i_host.wr(4'(a), r[7:0]);
      rd(4'(a), 8'h00);
    end
    repeat (4) begin
      r = $random(seed);
      i_host.wr(OFS_OPT_A, r[7:0]);
      rd(OFS_OPT_A, r[7:0] & OPT_A_MASK);
      check({7'h00, parity_check_en}, {7'h00, ~r[PAR_BIT]});
      i_host.wr(OFS_OPT_B, r[15:8] & 8'hFB);
      rd(OFS_OPT_B, r[15:8] & 8'h18);
      check({7'h00, contention_det_en}, {7'h00, ~r[8+CCD_BIT]});
    end
    i_host.wr(OFS_OPT_B, 8'h00);
    for (int i = 0; i < 7; i++) begin
      i_host.wr(OFS_OPT_A, (i == 6) ? 8'h20 : 8'h00);
      @(negedge clk) ev = EV[i];
      @(negedge clk) ev = 5'h00;
      rd(OFS_ERRSIG, {5'h00, EC[i]});
      rd(OFS_ERRSIG, 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      i_host.wr(OFS_OPT_A, k[0] ? 8'h10 : 8'h00);
      @(negedge clk) acc_waiting = 1'b1;
      repeat (TMO + 4) @(negedge clk);
      acc_waiting = 1'b0;
      rd(OFS_ERRSIG, k[0] ? 8'h00 : {5'h00, ERR_TIMEOUT});
    end
    for (int k = 0; k < 2; k++) begin
      i_host.wr(OFS_OPT_A, k[0] ? 8'h08 : 8'h00);
      pulse(ack_req);
      check({7'h00, ack_send}, {7'h00, ~k[0]});
      i_host.wr(OFS_OPT_B, k[0] ? 8'h10 : 8'h00);
      @(negedge clk) access_busy = 1'b1;
      @(negedge clk) sys_in_reset = 1'b1;
      seen = 1'b0;
      repeat (3) @(negedge clk) seen |= nack_send;
      check({7'h00, seen}, {7'h00, ~k[0]});
      sys_in_reset = 1'b0;
      access_busy = 1'b0;
      rd(OFS_OPT_B, k[0] ? 8'h10 : 8'h00);
    end
    for (int c = 0; c < 8; c++) begin
      i_host.wr(OFS_OPT_A, 8'(c));
      g = (c == 7) ? 2 : 128 >> c;
      pulse(dir_to_tx);
      n = 0;
      while (tx_hold === 1'b1 && n < 300) begin
        n++;
        @(negedge clk);
      end
      check({7'h00, n >= g && n <= g + 2}, 8'h01);
    end
    multi_load = 1'b1;
    for (int k = 0; k < 2; k++) begin
      i_host.wr(OFS_OPT_A, k[0] ? 8'h80 : 8'h00);
      pulse(byte_sent);
      pulse(bit_tick);
      check({7'h00, tx_hold}, {7'h00, k[0]});
      pulse(bit_tick);
      repeat (2) @(negedge clk);
      check({7'h00, tx_hold}, 8'h00);
    end
    pulse(key_u);
    rd(OFS_KEYS, 8'h20);
    i_host.wr(OFS_SYSCTL, 8'h03);
    check({7'h00, urow_done}, 8'h01);
    i_host.wr(OFS_KEYS, 8'h20);
    check({7'h00, urow_session_end}, 8'h01);
    rd(OFS_KEYS, 8'h00);
    pulse(key_p);
    rd(OFS_KEYS, 8'h10);
    @(negedge clk) prog_ready = 1'b1;
    rd(OFS_KEYS, 8'h00);
    prog_ready = 1'b0;
    pulse(key_e);
    rd(OFS_KEYS, 8'h08);
    i_host.wr(OFS_RESET_REQUEST_BYTE, RESET_REQUEST_BYTE_SIG);
    check({7'h00, sys_reset_out}, 8'h01);
    rd(OFS_KEYS, 8'h00);
    i_host.wr(OFS_RESET_REQUEST_BYTE, 8'h5A);
    check({7'h00, sys_reset_out}, 8'h00);
    rd(OFS_RESET_REQUEST_BYTE, 8'h5A);
    i_host.wr(OFS_RESET_REQUEST_BYTE, RESET_REQUEST_BYTE_RUN);
    for (int v = 0; v < 4; v++) begin
      i_host.wr(OFS_CLKDIV, 8'(v));
      check({6'h00, link_clock_select}, 8'(v));
      rd(OFS_CLKDIV, 8'(v));
    end
    i_host.wr(OFS_OPT_A, 8'hA5);
    i_host.wr(OFS_CLKDIV, 8'h01);
    i_host.wr(OFS_OPT_B, 8'h04);
    @(negedge clk);
    check({6'h00, phy_off, clk_req}, 8'h02);
    rd(OFS_OPT_A, 8'h00);
    rd(OFS_CLKDIV, 8'h03);
    pulse(phy_wake);
    @(negedge clk);
    check({6'h00, phy_off, clk_req}, 8'h01);
    summarize();
  end
endmodule
